// >>> hw/fbrc_bit_sync.sv
// three-stage level synchroniser, changes once the last two stages agree
`timescale 1ns/1ps
module fbrc_bit_sync (
  input  wire logic clk_in,
  input  wire logic level_in,
  output logic      level_out
);

  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clk_in) begin
    stage1 <= level_in;
    stage2 <= stage1;
    stage3 <= stage2;
  end

  always_ff @(posedge clk_in) begin
    if (stage2 == stage3) begin
      level_out <= stage3;
    end
  end

endmodule // fbrc_bit_sync

// >>> hw/fbrc_pkg.sv
// types shared by the burst read engine
package fbrc_pkg;

  typedef enum logic [1:0] {
    FBRC_ST_IDLE = 2'b00,
    FBRC_ST_WAIT = 2'b01,
    FBRC_ST_DATA = 2'b11
  } fbrc_state_t;

endpackage

// >>> hw/fbrc_regs.svh
// burst configuration register layout, defaults and burst timing constants
// Operation
// - a burst returns 2, 4 or 8 double words from the aligned group
// - output starts at the start index and increments modulo the group size
// - end-of-burst flag goes low on the final transfer before the wrap
// - continued clocking without a new address strobe wraps to the start
// - flag floats while output enable is off, otherwise driven high until eob; the engine also floats it while chip select is high
// - timing bit clear flags the last transfer, set flags the one before
// - each burst word stays on the bus for one clock; hold bit 1 reserved
// - hardware reset ends the burst, floats the bus, restores defaults
// - chip select high leaves the burst at once and floats the data bus
// - address latched on first clock edge with address valid low; the engine relatches on every such edge, so the last one wins
// - address valid low mid-burst discards it; new burst once it rises
// - output enable off only floats the bus; the sequence keeps advancing
// - initial latency is the latency code plus two clocks, default nine
// - the latency setting does not touch asynchronous reads
// - read mode bit 0 selects burst reads, 1 asynchronous, 1 by default
// - after reset the device reads asynchronously with default settings
// - chip select high leaves the configuration register unchanged
// - register always readable; writes during program or erase are ignored
// - register is 16 bits on the low lines, upper 16 lines read zero
// - register read latches a bank; that bank returns register contents
// - length codes 001, 010, 011 give 2, 4, 8; other codes disable bursts
`ifndef FBRC_REGS_SVH
`define FBRC_REGS_SVH

`define FBRC_CFG_RESET       16'h9cc3
`define FBRC_CFG_READ_MODE   15
`define FBRC_CFG_LAT_HI      13
`define FBRC_CFG_LAT_LO      10
`define FBRC_CFG_HOLD        9
`define FBRC_CFG_IND_TIMING  8
`define FBRC_CFG_ORDER       7
`define FBRC_CFG_CLK_EDGE    6
`define FBRC_CFG_LEN_HI      2
`define FBRC_CFG_LEN_LO      0
`define FBRC_LEN_CODE_2      3'h1
`define FBRC_LEN_CODE_4      3'h2
`define FBRC_LEN_CODE_8      3'h3
`define FBRC_LEN_2           4'h2
`define FBRC_LEN_4           4'h4
`define FBRC_LEN_8           4'h8
`define FBRC_LEN_NONE        4'h0
`define FBRC_LAT_BASE        5'h01
`define FBRC_LAT_LAST        5'h01
`define FBRC_UPPER_ZERO      16'h0000

`endif

// >>> hw/fbrc_top.sv
// burst read engine and burst configuration register
`timescale 1ns/1ps
`include "fbrc_regs.svh"
module fbrc_top #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 32
) (
  input  wire logic              clk_sys_in,
  input  wire logic              reset_n_in,
  input  wire logic              cfg_wr_in,
  input  wire logic [15:0]       cfg_wdata_in,
  input  wire logic              algo_busy_in,
  input  wire logic              cfg_rd_cmd_in,
  input  wire logic              cfg_rd_bank_in,
  input  wire logic              cfg_rd_exit_in,
  input  wire logic              read_bank_in,
  output logic      [DATA_W-1:0] cfg_rdata_out,
  output logic                   cfg_sel_out,
  input  wire logic              burst_clk_in,
  input  wire logic              chip_sel_n_in,
  input  wire logic              addr_valid_n_in,
  input  wire logic              out_en_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] array_rdata_in,
  output logic      [ADDR_W-1:0] array_addr_out,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe_out,
  output logic                   end_of_burst_flag_n_out,
  output logic                   end_of_burst_flag_n_oe_out,
  output logic                   burst_active_out
);

  // ---------------- system clock side: register and its reads
  logic [15:0] burst_configuration;
  logic        cfg_load;
  logic        reg_read_armed;
  logic        reg_read_bank;

  // writes refused while a program or erase algorithm runs
  assign cfg_load = cfg_wr_in & ~algo_busy_in;

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      burst_configuration <= `FBRC_CFG_RESET;
    end else if (cfg_load) begin
      burst_configuration <= cfg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      reg_read_armed <= 1'b0;
      reg_read_bank  <= 1'b0;
    end else if (cfg_rd_cmd_in) begin
      reg_read_armed <= 1'b1;
      reg_read_bank  <= cfg_rd_bank_in;
    end else if (cfg_rd_exit_in) begin
      reg_read_armed <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      cfg_rdata_out <= '0;
      cfg_sel_out   <= 1'b0;
    end else begin
      cfg_rdata_out <= {`FBRC_UPPER_ZERO, burst_configuration};
      cfg_sel_out   <= reg_read_armed && (read_bank_in == reg_read_bank);
    end
  end

  // ---------------- crossing into the burst clock domain
  logic        rst_link_n;
  logic [15:0] cfg_link;

  fbrc_bit_sync u_reset_sync (
    .clk_in    (burst_clk_in),
    .level_in  (reset_n_in),
    .level_out (rst_link_n)
  );

  fbrc_word_sync #(
    .WIDTH (16),
    .INIT  (`FBRC_CFG_RESET)
  ) u_cfg_sync (
    .src_clk_in     (clk_sys_in),
    .src_reset_n_in (reset_n_in),
    .src_load_in    (cfg_load),
    .src_data_in    (cfg_wdata_in),
    .dst_clk_in     (burst_clk_in),
    .dst_reset_n_in (rst_link_n),
    .dst_data_out   (cfg_link)
  );

  // ---------------- burst clock side: burst engine
  function automatic logic [3:0] burst_len(input logic [2:0] code);
    case (code)
      `FBRC_LEN_CODE_2: burst_len = `FBRC_LEN_2;
      `FBRC_LEN_CODE_4: burst_len = `FBRC_LEN_4;
      `FBRC_LEN_CODE_8: burst_len = `FBRC_LEN_8;
      default:          burst_len = `FBRC_LEN_NONE;
    endcase
  endfunction

  fbrc_pkg::fbrc_state_t state;
  fbrc_pkg::fbrc_state_t next_state;
  logic [3:0] len;
  logic [2:0] wrap_mask;
  logic [2:0] last_beat;
  logic [2:0] flag_beat;
  logic       burst_en;
  logic [4:0] lat_cnt;
  logic [4:0] lat_load;
  logic [2:0] beat;
  logic       latch;
  logic       emit;
  logic [2:0] next_low;

  assign len       = burst_len(cfg_link[`FBRC_CFG_LEN_HI:`FBRC_CFG_LEN_LO]);
  assign wrap_mask = 3'(len - 4'h1);
  assign last_beat = wrap_mask;
  // timing bit moves the flag one transfer earlier
  assign flag_beat = cfg_link[`FBRC_CFG_IND_TIMING] ?
                     3'(last_beat - 3'h1) : last_beat;
  // async mode or a disabled length code leaves the engine idle
  assign burst_en  = !cfg_link[`FBRC_CFG_READ_MODE] &&
                     (len != `FBRC_LEN_NONE);
  // edges from latch to first sample, less the output register stage
  assign lat_load  = 5'(cfg_link[`FBRC_CFG_LAT_HI:`FBRC_CFG_LAT_LO]) +
                     `FBRC_LAT_BASE;
  assign latch     = !chip_sel_n_in && !addr_valid_n_in && burst_en;
  assign emit      = !chip_sel_n_in && !latch &&
                     ((state == fbrc_pkg::FBRC_ST_WAIT &&
                       lat_cnt == `FBRC_LAT_LAST) ||
                      state == fbrc_pkg::FBRC_ST_DATA);
  // increment inside the aligned group only
  assign next_low  = (array_addr_out[2:0] & ~wrap_mask) |
                     ((array_addr_out[2:0] + 3'h1) & wrap_mask);

  always_comb begin
    next_state = state;
    if (chip_sel_n_in) begin
      next_state = fbrc_pkg::FBRC_ST_IDLE;
    end else if (latch) begin
      next_state = fbrc_pkg::FBRC_ST_WAIT;
    end else begin
      case (state)
        fbrc_pkg::FBRC_ST_IDLE: next_state = fbrc_pkg::FBRC_ST_IDLE;
        fbrc_pkg::FBRC_ST_WAIT: begin
          if (lat_cnt == `FBRC_LAT_LAST) begin
            next_state = fbrc_pkg::FBRC_ST_DATA;
          end
        end
        fbrc_pkg::FBRC_ST_DATA: next_state = fbrc_pkg::FBRC_ST_DATA;
        default:                next_state = fbrc_pkg::FBRC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge burst_clk_in) begin
    if (!rst_link_n) begin
      state <= fbrc_pkg::FBRC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge burst_clk_in) begin
    if (!rst_link_n) begin
      lat_cnt <= '0;
    end else if (latch) begin
      lat_cnt <= lat_load;
    end else if (state == fbrc_pkg::FBRC_ST_WAIT &&
                 lat_cnt != `FBRC_LAT_LAST) begin
      lat_cnt <= lat_cnt - 5'h01;
    end
  end

  // address and beat advance regardless of output enable
  always_ff @(posedge burst_clk_in) begin
    if (!rst_link_n) begin
      array_addr_out <= '0;
      beat           <= '0;
    end else if (latch) begin
      array_addr_out <= addr_in;
      beat           <= '0;
    end else if (emit) begin
      array_addr_out <= {array_addr_out[ADDR_W-1:3], next_low};
      beat           <= (beat == last_beat) ? 3'h0 : 3'(beat + 3'h1);
    end
  end

  always_ff @(posedge burst_clk_in) begin
    if (!rst_link_n) begin
      dq_out    <= '0;
      dq_oe_out <= 1'b0;
    end else begin
      if (emit) begin
        dq_out <= array_rdata_in;
      end
      dq_oe_out <= emit && !out_en_n_in;
    end
  end

  always_ff @(posedge burst_clk_in) begin
    if (!rst_link_n) begin
      end_of_burst_flag_n_out    <= 1'b1;
      end_of_burst_flag_n_oe_out <= 1'b0;
    end else begin
      end_of_burst_flag_n_out    <= !(emit && beat == flag_beat);
      end_of_burst_flag_n_oe_out <= !out_en_n_in && !chip_sel_n_in;
    end
  end

  always_ff @(posedge burst_clk_in) begin
    if (!rst_link_n) begin
      burst_active_out <= 1'b0;
    end else begin
      burst_active_out <= (next_state != fbrc_pkg::FBRC_ST_IDLE);
    end
  end

endmodule // fbrc_top

// >>> hw/fbrc_word_sync.sv
// toggle handshake carrying a held word into another clock domain
`timescale 1ns/1ps
module fbrc_word_sync #(
  parameter int           WIDTH = 16,
  parameter [WIDTH-1:0]   INIT  = '0
) (
  input  wire logic             src_clk_in,
  input  wire logic             src_reset_n_in,
  input  wire logic             src_load_in,
  input  wire logic [WIDTH-1:0] src_data_in,
  input  wire logic             dst_clk_in,
  input  wire logic             dst_reset_n_in,
  output logic      [WIDTH-1:0] dst_data_out
);

  logic [WIDTH-1:0] held;
  logic             src_toggle;
  logic             tgl1;
  logic             tgl2;
  logic             tgl3;
  logic             seen;

  // word held steady until the next load so the far side reads it whole
  always_ff @(posedge src_clk_in) begin
    if (!src_reset_n_in) begin
      held       <= INIT;
      src_toggle <= 1'b0;
    end else if (src_load_in) begin
      held       <= src_data_in;
      src_toggle <= ~src_toggle;
    end
  end

  always_ff @(posedge dst_clk_in) begin
    tgl1 <= src_toggle;
    tgl2 <= tgl1;
    tgl3 <= tgl2;
  end

  always_ff @(posedge dst_clk_in) begin
    if (!dst_reset_n_in) begin
      dst_data_out <= INIT;
      seen         <= 1'b0;
    end else if (tgl2 == tgl3 && tgl3 != seen) begin
      dst_data_out <= held;
      seen         <= tgl3;
    end
  end

endmodule // fbrc_word_sync

// >>> verification/fbrc_host_model.sv
// host controller model: burst clock and strobes
`timescale 1ns/1ps
module fbrc_host_model #(
  parameter int ADDR_W = 20
) (
  input  wire logic              run_in,
  output logic                   burst_clk_out,
  output logic                   chip_sel_n_out,
  output logic                   addr_valid_n_out,
  output logic                   out_en_n_out,
  output logic      [ADDR_W-1:0] addr_out
);
  initial begin
    burst_clk_out = 1'b0;
    chip_sel_n_out = 1'b1;
    addr_valid_n_out = 1'b1;
    out_en_n_out = 1'b1;
    addr_out = '0;
  end
  always #80 burst_clk_out = run_in ? ~burst_clk_out : 1'b0;
  // strobes move 1 ns after the rising burst clock edge
  task automatic start(input logic [ADDR_W-1:0] a);
    @(posedge burst_clk_out);
    #1;
    chip_sel_n_out = 1'b0;
    out_en_n_out = 1'b0;
    addr_valid_n_out = 1'b0;
    addr_out = a;
    @(posedge burst_clk_out);
    #1;
    addr_valid_n_out = 1'b1;
    addr_out = ~a;
  endtask
  task automatic out_en(input logic v);
    @(posedge burst_clk_out);
    #1;
    out_en_n_out = ~v;
  endtask
  task automatic stop();
    @(posedge burst_clk_out);
    #1;
    chip_sel_n_out = 1'b1;
    out_en_n_out = 1'b1;
  endtask
endmodule // fbrc_host_model

// >>> verification/fbrc_monitor.sv
// port assertions for the burst read engine
`timescale 1ns/1ps
module fbrc_monitor #(
  parameter int DATA_W = 32
) (
  input wire logic              clk_sys_in,
  input wire logic              reset_n_in,
  input wire logic              cfg_wr_in,
  input wire logic              algo_busy_in,
  input wire logic [DATA_W-1:0] cfg_rdata_out,
  input wire logic              burst_clk_in,
  input wire logic              chip_sel_n_in,
  input wire logic              addr_valid_n_in,
  input wire logic              out_en_n_in,
  input wire logic              dq_oe_out,
  input wire logic              end_of_burst_flag_n_out,
  input wire logic              end_of_burst_flag_n_oe_out,
  input wire logic              burst_active_out
);
  property p_oe_off;
    @(posedge burst_clk_in) disable iff (!reset_n_in)
    out_en_n_in && burst_active_out && !chip_sel_n_in && addr_valid_n_in
    |=> !dq_oe_out && burst_active_out;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe off");
  property p_flag_float;
    @(posedge burst_clk_in) disable iff (!reset_n_in)
    out_en_n_in |=> !end_of_burst_flag_n_oe_out;
  endproperty
  a_flag_float: assert property (p_flag_float) else $error("flag oe");
  property p_cs_exit;
    @(posedge burst_clk_in) disable iff (!reset_n_in)
    chip_sel_n_in |=> !dq_oe_out && !burst_active_out;
  endproperty
  a_cs_exit: assert property (p_cs_exit) else $error("cs exit");
  property p_flag_pulse;
    @(posedge burst_clk_in) disable iff (!reset_n_in)
    $fell(end_of_burst_flag_n_out) |=> end_of_burst_flag_n_out;
  endproperty
  a_flag_pulse: assert property (p_flag_pulse) else $error("flag");
  property p_upper_zero;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    cfg_rdata_out[DATA_W-1:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper");
  property p_cfg_write;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    $changed(cfg_rdata_out) |-> !$past(reset_n_in, 2)
    || ($past(cfg_wr_in, 2) && !$past(algo_busy_in, 2));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("cfg");
  property p_reset_float;
    @(posedge burst_clk_in) (!reset_n_in) [*6] |-> !dq_oe_out;
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("reset");
  property p_latch;
    @(posedge burst_clk_in) disable iff (!reset_n_in)
    $rose(burst_active_out) |-> !$past(addr_valid_n_in) && !$past(chip_sel_n_in);
  endproperty
  a_latch: assert property (p_latch) else $error("latch");
endmodule // fbrc_monitor
bind fbrc_top fbrc_monitor #(.DATA_W(DATA_W)) i_fbrc_monitor (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .cfg_wr_in(cfg_wr_in),
  .algo_busy_in(algo_busy_in), .cfg_rdata_out(cfg_rdata_out),
  .burst_clk_in(burst_clk_in), .chip_sel_n_in(chip_sel_n_in),
  .addr_valid_n_in(addr_valid_n_in), .out_en_n_in(out_en_n_in),
  .dq_oe_out(dq_oe_out), .end_of_burst_flag_n_out(end_of_burst_flag_n_out),
  .end_of_burst_flag_n_oe_out(end_of_burst_flag_n_oe_out),
  .burst_active_out(burst_active_out));

// >>> verification/tb.sv
// testbench for the burst read engine
`timescale 1ns/1ps
`include "fbrc_regs.svh"
module tb;
  logic        clk_sys_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        wr = 1'b0;
  logic        busy = 1'b0;
  logic        rd_cmd = 1'b0;
  logic        rd_exit = 1'b0;
  logic        rd_bank = 1'b0;
  logic        bank = 1'b0;
  logic [15:0] wdata = '0;
  logic [15:0] cfg_now = `FBRC_CFG_RESET;
  logic [31:0] rdata, dq, arr;
  logic [19:0] aaddr, addr;
  logic        sel, bclk, cs_n, avd_n, oe_n, dq_oe, fl_n, fl_oe, act;
  int          fail_count = 0;
  int          check_count = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  assign arr = {12'h000, aaddr};
  fbrc_host_model i_fbrc_host_model (.run_in(1'b1), .burst_clk_out(bclk),
    .chip_sel_n_out(cs_n), .addr_valid_n_out(avd_n), .out_en_n_out(oe_n),
    .addr_out(addr));
  fbrc_top i_fbrc_top (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .cfg_wr_in(wr), .cfg_wdata_in(wdata), .algo_busy_in(busy),
    .cfg_rd_cmd_in(rd_cmd), .cfg_rd_bank_in(rd_bank), .cfg_rd_exit_in(rd_exit),
    .read_bank_in(bank), .cfg_rdata_out(rdata), .cfg_sel_out(sel),
    .burst_clk_in(bclk), .chip_sel_n_in(cs_n), .addr_valid_n_in(avd_n),
    .out_en_n_in(oe_n), .addr_in(addr), .array_rdata_in(arr),
    .array_addr_out(aaddr), .dq_out(dq), .dq_oe_out(dq_oe),
    .end_of_burst_flag_n_out(fl_n), .end_of_burst_flag_n_oe_out(fl_oe),
    .burst_active_out(act));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic sys(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic bcy(input int n);
    repeat (n) @(posedge bclk);
    #1;
  endtask
  task automatic cfg_write(input logic [15:0] d, input logic b);
    sys(1);
    wr = 1'b1;
    wdata = d;
    busy = b;
    sys(1);
    wr = 1'b0;
    busy = 1'b0;
    if (!b) cfg_now = d;
    sys(3);
    chk("cfg", {16'h0000, cfg_now}, rdata);
    // let the new setting cross into the burst clock domain
    bcy(6);
  endtask
  task automatic t_none();
    i_fbrc_host_model.start(20'h00011);
    bcy(12);
    chk("dq_oe", 0, dq_oe);
    i_fbrc_host_model.stop();
  endtask
  task automatic t_sel();
    sys(1);
    rd_cmd = 1'b1;
    rd_bank = 1'b1;
    bank = 1'b1;
    sys(1);
    rd_cmd = 1'b0;
    sys(2);
    chk("sel", 1, sel);
    bank = 1'b0;
    sys(2);
    chk("sel", 0, sel);
    rd_cmd = 1'b1;
    rd_bank = 1'b0;
    sys(1);
    rd_cmd = 1'b0;
    sys(2);
    chk("sel", 1, sel);
    rd_exit = 1'b1;
    sys(1);
    rd_exit = 1'b0;
    sys(2);
    chk("sel", 0, sel);
  endtask
  task automatic t_burst(input logic [2:0] c, input logic [3:0] lat,
                         input logic tm, input logic [19:0] a);
    int len;
    int k;
    len = 1 << c;
    cfg_write({2'b00, lat, 1'b0, tm, 2'b11, 3'b000, c}, 1'b0);
    bcy(8);
    i_fbrc_host_model.start(a);
    k = 0;
    do begin
      bcy(1);
      k++;
    end while (dq_oe !== 1'b1 && k < 20);
    chk("latency", 32'(lat) + 1, 32'(k));
    chk("flag_oe", 1, fl_oe);
    for (int i = 0; i < 2 * len; i++) begin
      chk("word", 32'((a & ~(len - 1)) | ((a + i) % len)), dq);
      chk("flag", (i % len == len - 1 - tm) ? 0 : 1, fl_n);
      bcy(1);
    end
  endtask
  task automatic t_oe();
    i_fbrc_host_model.out_en(1'b0);
    bcy(1);
    chk("dq_oe", 0, dq_oe);
    chk("flag_oe", 0, fl_oe);
    i_fbrc_host_model.out_en(1'b1);
    bcy(1);
    chk("dq_oe", 1, dq_oe);
    chk("word", 32'h00000031, dq);
  endtask
  task automatic t_cs();
    i_fbrc_host_model.stop();
    bcy(1);
    chk("active", 0, act);
    chk("dq_oe", 0, dq_oe);
    chk("cfg", {16'h0000, cfg_now}, rdata);
  endtask
  task automatic t_rst();
    t_burst(3'h3, 4'h7, 1'b1, 20'h00046);
    sys(1);
    reset_n_in = 1'b0;
    bcy(7);
    chk("dq_oe", 0, dq_oe);
    sys(1);
    reset_n_in = 1'b1;
    cfg_now = `FBRC_CFG_RESET;
    bcy(6);
    chk("cfg", {16'h0000, cfg_now}, rdata);
    t_none();
  endtask
  task automatic results();
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    results();
  end
  initial begin
    bcy(12);
    sys(1);
    reset_n_in = 1'b1;
    bcy(6);
    chk("cfg", {16'h0000, `FBRC_CFG_RESET}, rdata);
    cfg_write(16'h1234, 1'b1);
    t_none();
    t_sel();
    t_burst(3'h1, 4'h0, 1'b0, 20'h00011);
    t_burst(3'h2, 4'h0, 1'b1, 20'h00021);
    t_burst(3'h3, 4'h1, 1'b1, 20'h0002e);
    t_burst(3'h3, 4'h0, 1'b0, 20'h00035);
    t_oe();
    t_cs();
    cfg_write(16'h00c0, 1'b0);
    t_none();
    cfg_write(16'h00c4, 1'b0);
    t_none();
    t_rst();
    results();
  end
endmodule // tb
